// ---- hw/ips_irq_priority_select.sv ----
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "ips_defines.svh"

module ips_irq_priority_select (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [5:0] std_irq_req,
  input wire logic [6:0] ext_irq_req,
  input wire logic svc_enter,
  input wire logic svc_return,
  output logic [5:0] std_irq_gated,
  output logic [6:0] ext_irq_gated,
  output logic irq_take,
  output logic [2:0] irq_take_id,
  output logic irq_take_high
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ips_pkg::ips_reg_t irq_level_select;
  ips_pkg::ips_reg_t irq_enable_extended;
  ips_pkg::ips_reg_t irq_enable_std;
  logic in_low;
  logic in_high;

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;
  logic do_write;
  logic wr_ok;
  logic bvalid_q;

  // Handshakes are masked while frozen, so no beat is lost or taken twice
  assign s_axi_awready = clk_en & ~aw_held & ~bvalid_q;
  assign s_axi_wready = clk_en & ~w_held & ~bvalid_q;
  assign s_axi_bvalid = clk_en & bvalid_q;
  assign do_write = clk_en & aw_held & w_held & ~bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_comb begin
    if (aw_addr == `IPS_OFF_LEVEL) begin
      wr_ok = 1'b1;
    end else if (aw_addr == `IPS_OFF_ENX) begin
      wr_ok = 1'b1;
    end else if (aw_addr == `IPS_OFF_ENSTD) begin
      wr_ok = 1'b1;
    end else if (aw_addr == `IPS_OFF_STATUS) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (clk_en) begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Only lane 0 carries register bits; other lanes are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_level_select <= `IPS_RST_LEVEL;
    end else if (do_write && w_lane0 && aw_addr == `IPS_OFF_LEVEL) begin
      irq_level_select <= w_data & `IPS_LVL_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_extended <= `IPS_RST_ENX;
    end else if (do_write && w_lane0 && aw_addr == `IPS_OFF_ENX) begin
      irq_enable_extended <= w_data & `IPS_ENX_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_std <= `IPS_RST_ENSTD;
    end else if (do_write && w_lane0 && aw_addr == `IPS_OFF_ENSTD) begin
      irq_enable_std <= w_data & `IPS_ENSTD_MASK;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  logic [7:0] rd_val;
  logic rd_ok;
  logic rvalid_q;

  assign s_axi_arready = clk_en & ~rvalid_q;
  assign s_axi_rvalid = clk_en & rvalid_q;

  always_comb begin
    rd_ok = 1'b1;
    if (s_axi_araddr == `IPS_OFF_LEVEL) begin
      rd_val = irq_level_select;
    end else if (s_axi_araddr == `IPS_OFF_ENX) begin
      rd_val = irq_enable_extended;
    end else if (s_axi_araddr == `IPS_OFF_ENSTD) begin
      rd_val = irq_enable_std;
    end else if (s_axi_araddr == `IPS_OFF_STATUS) begin
      rd_val = {4'h0, irq_take_high, in_high, in_low, irq_take};
    end else begin
      rd_val = 8'h00;
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_q <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Gating and level selection
  // ----------------------------------------
  logic global_irq_gate;
  logic [5:0] std_level;
  logic [5:0] std_live;
  logic [6:0] ext_live;

  assign global_irq_gate = irq_enable_std[`IPS_GATE_BIT];
  // Standard enable bit 5 is reserved, so UART1 maps from bit 6
  assign std_live = std_irq_req & {irq_enable_std[6], irq_enable_std[4:0]}
                    & {6{global_irq_gate}};
  assign ext_live = ext_irq_req & irq_enable_extended[6:0] & {7{global_irq_gate}};
  assign std_level = {irq_level_select[`IPS_LVL_SER1],
                      irq_level_select[`IPS_LVL_SER0],
                      irq_level_select[`IPS_LVL_TMR1],
                      irq_level_select[`IPS_LVL_EXT1],
                      irq_level_select[`IPS_LVL_TMR0],
                      irq_level_select[`IPS_LVL_EXT0]};

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  logic [5:0] hi_set;
  logic [5:0] lo_set;
  logic next_take;
  logic next_high;
  logic [2:0] next_id;
  logic busy_high;
  logic busy_low;

  // An acknowledge in this cycle already counts, or the same source is offered twice
  assign busy_high = in_high | (svc_enter & irq_take & irq_take_high);
  assign busy_low = in_low | (svc_enter & irq_take & ~irq_take_high);
  assign hi_set = std_live & std_level;
  assign lo_set = std_live & ~std_level;

  // Polling order: lowest index first; high level blocked only by high service
  always_comb begin
    next_take = 1'b0;
    next_high = 1'b0;
    next_id = 3'd0;
    if (|hi_set && !busy_high) begin
      next_take = 1'b1;
      next_high = 1'b1;
      for (int i = 5; i >= 0; i--) begin
        if (hi_set[i]) begin
          next_id = 3'(i);
        end
      end
    end else if (|lo_set && !busy_high && !busy_low) begin
      next_take = 1'b1;
      for (int i = 5; i >= 0; i--) begin
        if (lo_set[i]) begin
          next_id = 3'(i);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_take <= 1'b0;
      irq_take_high <= 1'b0;
      irq_take_id <= 3'd0;
    end else if (clk_en) begin
      irq_take <= next_take;
      irq_take_high <= next_high;
      irq_take_id <= next_id;
    end
  end

  // Service nesting: one low and one high level at most
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_low <= 1'b0;
      in_high <= 1'b0;
    end else if (clk_en) begin
      if (svc_enter && irq_take) begin
        if (irq_take_high) begin
          in_high <= 1'b1;
        end else begin
          in_low <= 1'b1;
        end
      end else if (svc_return) begin
        if (in_high) begin
          in_high <= 1'b0;
        end else begin
          in_low <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      std_irq_gated <= 6'h00;
      ext_irq_gated <= 7'h00;
    end else if (clk_en) begin
      std_irq_gated <= std_live;
      ext_irq_gated <= ext_live;
    end
  end

endmodule : ips_irq_priority_select

// ---- hw/ips_defines.svh ----
`ifndef IPS_DEFINES_SVH
`define IPS_DEFINES_SVH

// Register byte addresses
`define IPS_OFF_LEVEL 8'hB8
`define IPS_OFF_ENX 8'hE8
`define IPS_OFF_ENSTD 8'hA8
`define IPS_OFF_STATUS 8'hC0

// Level and enable register fields
`define IPS_LVL_EXT0 0
`define IPS_LVL_TMR0 1
`define IPS_LVL_EXT1 2
`define IPS_LVL_TMR1 3
`define IPS_LVL_SER0 4
`define IPS_LVL_SER1 6
`define IPS_LVL_MASK 8'h5F
`define IPS_ENX_MASK 8'h7F
`define IPS_ENSTD_MASK 8'hDF
`define IPS_GATE_BIT 7

// Reset values
`define IPS_RST_LEVEL 8'h00
`define IPS_RST_ENX 8'h00
`define IPS_RST_ENSTD 8'h00

`define IPS_NSRC 6

`endif

// ---- hw/ips_pkg.sv ----
package ips_pkg;
  typedef enum logic [1:0] {
    IPS_IDLE = 2'b00,
    IPS_LOW = 2'b01,
    IPS_HIGH = 2'b11
  } ips_level_e;
  typedef logic [7:0] ips_reg_t;
  typedef logic [2:0] ips_id_t;
endpackage : ips_pkg

// ---- testbench/ips_irq_priority_select_properties.sv ----
`timescale 1ns/10ps
// ---------------------------------
// Port checker
// ---------------------------------
module ips_prio_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [5:0] std_irq_req,
  input wire logic [6:0] ext_irq_req,
  input wire logic svc_enter,
  input wire logic [5:0] std_irq_gated,
  input wire logic [6:0] ext_irq_gated,
  input wire logic irq_take,
  input wire logic [2:0] irq_take_id,
  input wire logic irq_take_high
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
    else $error("read answer late");
  rsvd_zero_a: assert property (s_axi_arvalid && s_axi_arready && clk_en
    && s_axi_araddr == 8'hB8 |=> (s_axi_rdata & 32'hFFFF_FFA0) == 32'h0000_0000)
    else $error("reserved level bits not zero");
  std_gate_a: assert property ($past(clk_en)
    |-> (std_irq_gated & ~$past(std_irq_req)) == 6'h00) else $error("std gated w/o request");
  ext_gate_a: assert property ($past(clk_en)
    |-> (ext_irq_gated & ~$past(ext_irq_req)) == 7'h00) else $error("ext gated w/o request");
  take_src_a: assert property (irq_take && $past(clk_en) |-> irq_take_id < 3'h6
    && (($past(std_irq_req) >> irq_take_id) & 6'h01) == 6'h01) else $error("bad take source");
  high_blk_a: assert property (irq_take && irq_take_high && svc_enter && clk_en
    |=> !irq_take) else $error("offer during high service");

  hi_c: cover property (irq_take && irq_take_high && svc_enter);
  lo_c: cover property (irq_take && !irq_take_high);
  rd_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ips_prio_checker

bind ips_irq_priority_select ips_prio_checker chk (.*);

// ---- testbench/ips_irq_priority_select_test.sv ----
`timescale 1ns/10ps
module ips_irq_priority_select_test;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0, irq_take_id;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, svc_enter = 1'b0, svc_return = 1'b0, irq_take, irq_take_high;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [5:0] std_irq_req = '0, std_irq_gated;
  logic [6:0] ext_irq_req = '0, ext_irq_gated;
  int failures = 0, n_tests = 0, lag = 0;

  ips_irq_priority_select dut (.*);

  initial forever #5 aclk = ~aclk;
  // ---------------------------------
  // Bus and compare tasks
  // ---------------------------------
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  // Lag holds back the response ready for that many edges
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (lag == 0);
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    repeat (lag) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (lag == 0);
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    repeat (lag) @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr
  // Requests take one edge to show on gated outputs, so wait three
  task automatic req(input logic [5:0] s, input logic [6:0] x);
    @(posedge aclk);
    std_irq_req <= s;
    ext_irq_req <= x;
    repeat (3) @(posedge aclk);
    #1;
  endtask : req
  task automatic pulse(input logic ret);
    @(posedge aclk);
    if (ret) svc_return <= 1'b1;
    else svc_enter <= 1'b1;
    @(posedge aclk);
    svc_enter <= 1'b0;
    svc_return <= 1'b0;
  endtask : pulse
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ---------------------------------
  // Tests
  // ---------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    lag = 2;
    rdr(8'hB8);
    chk("level_rst", 0, rd);
    chk("rd_okay", 0, 32'(rsp));
    rdr(8'hE8);
    chk("enx_rst", 0, rd);
    wr(8'hB8, 8'hFF);
    chk("wr_okay", 0, 32'(rsp));
    lag = 0;
    rdr(8'hB8);
    chk("level_rsvd", 32'h0000_005F, rd);
    wr(8'hE8, 8'hFF);
    rdr(8'hE8);
    chk("enx_rsvd", 32'h0000_007F, rd);
    // Lane 0 strobe low: answered, but nothing changes
    s_axi_wstrb <= 4'h0;
    wr(8'hE8, 8'h00);
    s_axi_wstrb <= 4'h1;
    rdr(8'hE8);
    chk("enx_nostrb", 32'h0000_007F, rd);
    rdr(8'h10);
    chk("rd_err", 32'(2'b10), 32'(rsp));
    wr(8'h10, 8'hAA);
    chk("wr_err", 32'(2'b10), 32'(rsp));
    wr(8'hA8, 8'hDF);
    req(6'h3F, 7'h55);
    chk("std_gated", 32'(6'h3F), 32'(std_irq_gated));
    chk("ext_gated", 32'(7'h55), 32'(ext_irq_gated));
    // Uart1 level sits at bit 6, bit 5 is a hole
    for (int i = 0; i < 6; i++) begin
      wr(8'hB8, 8'h01 << (i == 5 ? 6 : i));
      req(6'h3F, 7'h55);
      chk("take_id", i, 32'(irq_take_id));
      chk("take_high", 1, 32'(irq_take_high));
    end
    wr(8'hB8, 8'h00);
    req(6'h3F, 7'h55);
    chk("poll_id", 0, 32'(irq_take_id));
    wr(8'hB8, 8'h02);
    req(6'h01, 7'h00);
    chk("low_high", 0, 32'(irq_take_high));
    pulse(0);
    req(6'h01, 7'h00);
    chk("low_block", 0, 32'(irq_take));
    req(6'h03, 7'h00);
    chk("preempt_id", 1, 32'(irq_take_id));
    chk("preempt", 1, 32'(irq_take && irq_take_high));
    pulse(0);
    pulse(1);
    rdr(8'hC0);
    chk("nest_low", 32'h0000_000B, rd);
    pulse(1);
    rdr(8'hC0);
    chk("nest_idle", 32'h0000_0009, rd);
    // Enable low: gated requests and the offer stay frozen
    @(posedge aclk);
    clk_en <= 1'b0;
    req(6'h00, 7'h00);
    chk("frz_gated", 32'(6'h03), 32'(std_irq_gated));
    chk("frz_take", 1, 32'(irq_take));
    @(posedge aclk);
    clk_en <= 1'b1;
    wr(8'hA8, 8'h5F);
    wr(8'hE8, 8'h00);
    req(6'h3F, 7'h7F);
    chk("gate_off", 0, 32'(irq_take));
    chk("ext_off", 0, 32'(ext_irq_gated));
    print_verdict();
  end

  initial begin
    repeat (4000) @(posedge aclk);
    failures++;
    print_verdict();
  end
endmodule : ips_irq_priority_select_test
